// ---- verilog/spio_pkg.sv ----
// Purpose: shared constants and carrier types for the servo pulse input and status output block
// Assumes: 20 MHz system clock
// Notes:   status selector codes follow the drive's selectable output setting
package spio_pkg;

  // command pulse formats
  typedef enum logic [1:0] {
    SPIO_FMT_QUAD,
    SPIO_FMT_CW_CCW,
    SPIO_FMT_PULSE_SIGN
  } spio_fmt_t;

  // selectable status output codes
  localparam logic [2:0] SPIO_SEL_TORQUE_LIMIT = 3'h0;
  localparam logic [2:0] SPIO_SEL_ZERO_SPEED   = 3'h1;
  localparam logic [2:0] SPIO_SEL_ANY_WARNING  = 3'h2;
  localparam logic [2:0] SPIO_SEL_REGEN_WARN   = 3'h3;
  localparam logic [2:0] SPIO_SEL_OVERLOAD     = 3'h4;
  localparam logic [2:0] SPIO_SEL_BATTERY      = 3'h5;
  localparam logic [2:0] SPIO_SEL_RESET        = SPIO_SEL_ZERO_SPEED;

  // widths
  localparam int SPIO_NUM_W   = 16;
  localparam int SPIO_CNT_W   = 32;
  localparam int SPIO_SPEED_W = 16;
  localparam int SPIO_POS_W   = SPIO_CNT_W + SPIO_NUM_W;

  // host guard time around scaler switching
  localparam int SPIO_CLK_HZ       = 20_000_000;
  localparam int SPIO_GUARD_MS     = 10;
  localparam int SPIO_GUARD_CYCLES = SPIO_CLK_HZ / 1000 * SPIO_GUARD_MS;

  // drive condition inputs from the rest of the drive
  typedef struct packed {
    logic trip;
    logic main_power_drive;
    logic main_power_motor;
    logic brake_release_req;
    logic torque_limiting;
    logic regen_warn;
    logic overload_warn;
    logic battery_warn;
  } spio_cond_t;

  // status outputs toward the host
  typedef struct packed {
    logic fault_out;
    logic servo_ready_out;
    logic brake_release_out;
    logic selectable_status_out;
  } spio_status_t;

endpackage : spio_pkg

// ---- verilog/spio_top.sv ----
// Purpose: command pulse decode, scaler select and host status outputs of a servo drive
// Assumes: pin inputs asynchronous to clk; warnings and speed come from drive logic on clk
// Notes:   output levels are "transistor on" = 1
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - accept quadrature, cw/ccw pulse pair, or pulse plus sign, chosen by setting
// R2 - scaler-select closed to common return picks the second numerator
// R3 - host sends no pulses within 10 ms either side of a scaler-select change
// R4 - fault output goes off whenever a trip is detected
// R5 - ready only with drive and motor main power on and no alarm
// R6 - brake release output on exactly while the brake is to be released
// R7 - selection 0 drives status output on while torque limiting
// R8 - selection 1, the default, drives status output on below zero-speed threshold
// R9 - selection 2 drives status output on for any regen, overload or battery warning
// R10 - selection 3 drives status output on for the regeneration warning
// R11 - selection 4 drives status output on for the overload warning
// R12 - selection 5 drives status output on for the low battery warning
// R13 - selections 2 to 5 also turn the status output on upon alarm
// R14 - quadrature counts every phase edge; other modes count pulse edges with direction; the code drops quadrature a and b edges that land in one sample
// R15 - position command is pulse count times the selected numerator
module spio_top #(
  parameter int NUM_W   = spio_pkg::SPIO_NUM_W,
  parameter int CNT_W   = spio_pkg::SPIO_CNT_W,
  parameter int SPEED_W = spio_pkg::SPIO_SPEED_W
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // command pulse pins (asynchronous)
  input  wire logic                   cmd_pulse_pos,
  input  wire logic                   cmd_direction_pos,
  input  wire logic                   scaler_select_closed,
  // configuration
  input  wire spio_pkg::spio_fmt_t    pulse_format_setting,
  input  wire logic [NUM_W-1:0]       scaler_numerator_first,
  input  wire logic [NUM_W-1:0]       scaler_numerator_second,
  input  wire logic [2:0]             status_out_select,
  input  wire logic [SPEED_W-1:0]     zero_speed_threshold,
  // drive state
  input  wire logic [SPEED_W-1:0]     motor_speed_abs,
  input  wire spio_pkg::spio_cond_t   drive_cond,
  // results
  output logic signed [CNT_W-1:0]     pulse_count,
  output logic signed [CNT_W+NUM_W:0] position_command,
  output logic                        step_pulse,
  output spio_pkg::spio_status_t      status_out
);
  import spio_pkg::*;

  // refuse widths that the count and product logic cannot serve
  if (NUM_W < 1 || CNT_W < 2 || SPEED_W < 1) begin : g_bad_widths
    $error("spio_top: widths too small");
  end

  // reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_ok_n = rst_sync_reg;

  // two-stage synchronisers for the three pins, plus a history stage for edges
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_prev_reg;
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {scaler_select_closed, cmd_direction_pos, cmd_pulse_pos};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // edge history is trusted only once meta, sync and prev all hold real samples;
  // without this a pin that idles high would look like a rising edge after reset,
  // at the cost of ignoring pin activity in the first three cycles after release
  logic [2:0] warm_reg;
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      warm_reg <= 3'h0;
    end else begin
      warm_reg <= {warm_reg[1:0], 1'b1};
    end
  end
  wire logic hist_ok = warm_reg[2];

  wire logic a_now  = pin_sync_reg[0];
  wire logic b_now  = pin_sync_reg[1];
  wire logic a_prev = pin_prev_reg[0];
  wire logic b_prev = pin_prev_reg[1];
  wire logic a_edge = a_now ^ a_prev;
  wire logic b_edge = b_now ^ b_prev;
  wire logic a_rise = a_now & ~a_prev;
  wire logic b_rise = b_now & ~b_prev;

  // quadrature: any single phase edge is a step; forward when a leads b.
  // a double edge in one sample is a lost state and is dropped rather than guessed.
  wire logic quad_step = a_edge ^ b_edge;                       // [R14]
  wire logic quad_up   = (a_edge & (a_now ^ b_now)) | (b_edge & ~(a_now ^ b_now)); // [R14]

  // cw/ccw: rising edge on either line, both together cancel
  wire logic cw_step = a_rise ^ b_rise;                         // [R14]
  wire logic cw_up   = a_rise;                                  // [R14]

  // pulse/sign: rising pulse edge, direction from sign level
  wire logic ps_step = a_rise;                                  // [R14]
  wire logic ps_up   = ~b_now;                                  // [R14]

  // format selection
  logic sel_step;
  logic sel_up;
  always_comb begin
    case (pulse_format_setting)                                 // [R1]
      SPIO_FMT_QUAD: begin
        sel_step = quad_step;
        sel_up   = quad_up;
      end
      SPIO_FMT_CW_CCW: begin
        sel_step = cw_step;
        sel_up   = cw_up;
      end
      SPIO_FMT_PULSE_SIGN: begin
        sel_step = ps_step;
        sel_up   = ps_up;
      end
      default: begin
        sel_step = 1'b0;
        sel_up   = 1'b0;
      end
    endcase
  end

  // accumulated pulse count
  logic signed [CNT_W-1:0] count_reg;
  logic signed [CNT_W-1:0] count_next;
  logic                    step_reg;
  assign count_next = sel_up ? count_reg + CNT_W'(1) : count_reg - CNT_W'(1);
  // a step counts only once the edge history is trusted
  wire logic step_ok = sel_step & hist_ok;                      // [R14]
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      count_reg <= '0;
      step_reg  <= 1'b0;
    end else begin
      step_reg <= step_ok;
      if (step_ok) begin
        count_reg <= count_next;                                // [R14]
      end
    end
  end

  // numerator choice; the host keeps pulses away from changes so no blend is needed [R3]
  wire logic [NUM_W-1:0] numerator_sel = pin_sync_reg[2] ? scaler_numerator_second
                                                         : scaler_numerator_first; // [R2]

  // scaled position command, registered
  logic signed [CNT_W+NUM_W:0] pos_reg;
  // both operands widened to the product width first, so the product is never
  // evaluated at the count width and cut; the numerator is unsigned, hence the zero
  wire logic signed [CNT_W+NUM_W:0] count_wide = (CNT_W+NUM_W+1)'(count_reg);
  wire logic signed [CNT_W+NUM_W:0] num_wide   = (CNT_W+NUM_W+1)'({1'b0, numerator_sel});
  wire logic signed [CNT_W+NUM_W:0] pos_next   = count_wide * num_wide; // [R15]
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pos_reg <= '0;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // status decode
  wire logic alarm       = drive_cond.trip;
  wire logic zero_speed  = motor_speed_abs < zero_speed_threshold;
  wire logic any_warning = drive_cond.regen_warn | drive_cond.overload_warn | drive_cond.battery_warn;
  logic sel_raw;
  always_comb begin
    case (status_out_select)
      SPIO_SEL_TORQUE_LIMIT: sel_raw = drive_cond.torque_limiting;      // [R7]
      SPIO_SEL_ZERO_SPEED:   sel_raw = zero_speed;                      // [R8]
      SPIO_SEL_ANY_WARNING:  sel_raw = any_warning | alarm;             // [R9] [R13]
      SPIO_SEL_REGEN_WARN:   sel_raw = drive_cond.regen_warn | alarm;   // [R10] [R13]
      SPIO_SEL_OVERLOAD:     sel_raw = drive_cond.overload_warn | alarm; // [R11] [R13]
      SPIO_SEL_BATTERY:      sel_raw = drive_cond.battery_warn | alarm; // [R12] [R13]
      default:               sel_raw = 1'b0;
    endcase
  end

  // registered status outputs; the fault output is on while healthy, so it reads 0 in reset
  spio_status_t status_reg;
  spio_status_t status_next;
  always_comb begin
    status_next.fault_out             = ~alarm;                 // [R4]
    status_next.servo_ready_out       = drive_cond.main_power_drive & drive_cond.main_power_motor
                                        & ~alarm;               // [R5]
    status_next.brake_release_out     = drive_cond.brake_release_req; // [R6]
    status_next.selectable_status_out = sel_raw;
  end
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign pulse_count      = count_reg;
  assign position_command = pos_reg;
  assign step_pulse       = step_reg;
  assign status_out       = status_reg;

endmodule : spio_top

`default_nettype wire

// ---- sim/spio_checker.sv ----
// Purpose: concurrent checks on status and step outputs
// Assumes: bound into spio_top, one clock domain
// Notes:   live masks the internal two-flop reset release
`timescale 1ns/1ps
`default_nettype none
module spio_checker #(
  parameter int CNT_W   = spio_pkg::SPIO_CNT_W,
  parameter int SPEED_W = spio_pkg::SPIO_SPEED_W
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // causes
  input wire logic [2:0]              status_out_select,
  input wire logic [SPEED_W-1:0]      zero_speed_threshold,
  input wire logic [SPEED_W-1:0]      motor_speed_abs,
  input wire spio_pkg::spio_cond_t    drive_cond,
  // effects
  input wire logic signed [CNT_W-1:0] pulse_count,
  input wire logic                    step_pulse,
  input wire spio_pkg::spio_status_t  status_out
);
  import spio_pkg::*;
  logic [2:0] age_reg;
  logic       live;
  spio_cond_t cond_reg;
  // outputs trail rst_n by the synchroniser, so checks wait four edges
  assign live = age_reg == 3'h4;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) age_reg <= 3'h0;
    else if (!live) age_reg <= age_reg + 3'h1;
  end
  // condition copy one edge back, the cause of each registered status bit
  always_ff @(posedge clk) begin
    cond_reg <= drive_cond;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_fault_trip: assert property (live |-> status_out.fault_out == !cond_reg.trip)
    else $error("fault output wrong");
  chk_ready_power: assert property (live |-> status_out.servo_ready_out ==
    (cond_reg.main_power_drive && cond_reg.main_power_motor && !cond_reg.trip)) else $error("ready wrong");
  chk_brake_follow: assert property (live ##1 $rose(drive_cond.brake_release_req) |=> status_out.brake_release_out)
    else $error("brake release late");
  chk_sel_torque: assert property (live && $past(status_out_select) == 3'h0 |->
    status_out.selectable_status_out == cond_reg.torque_limiting) else $error("torque select wrong");
  chk_sel_speed: assert property (live && $past(status_out_select) == 3'h1 |-> status_out.selectable_status_out ==
    ($past(motor_speed_abs) < $past(zero_speed_threshold))) else $error("zero speed wrong");
  chk_sel_warn: assert property (live && $past(status_out_select) == 3'h2 |->
    status_out.selectable_status_out == (cond_reg[2:0] != 3'h0 || cond_reg.trip)) else $error("warn select wrong");
  chk_sel_single: assert property (live && $past(status_out_select) inside {3'h3, 3'h4, 3'h5} |->
    status_out.selectable_status_out == (cond_reg.trip || cond_reg[3'h5 - $past(status_out_select)]))
    else $error("single warn select wrong");
  chk_sel_none: assert property (live && $past(status_out_select) > 3'h5 |-> !status_out.selectable_status_out)
    else $error("unused select drives output");
  chk_step_count: assert property (live |-> step_pulse == (pulse_count != $past(pulse_count)))
    else $error("count moved without step");
endmodule : spio_checker
bind spio_top spio_checker #(.CNT_W(CNT_W), .SPEED_W(SPEED_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .status_out_select(status_out_select), .zero_speed_threshold(zero_speed_threshold),
  .motor_speed_abs(motor_speed_abs), .drive_cond(drive_cond), .pulse_count(pulse_count),
  .step_pulse(step_pulse), .status_out(status_out));
`default_nettype wire

// ---- sim/spio_host.sv ----
// Purpose: host controller model issuing command pulses
// Assumes: step is called just after a clk edge
// Notes:   each level held 4 cycles, past the 3-cycle capture floor
`timescale 1ns/1ps
`default_nettype none
module spio_host (
  // clock
  input wire logic clk,
  // pulse pins
  output logic     cmd_pulse_pos,
  output logic     cmd_direction_pos
);
  import spio_pkg::*;
  initial {cmd_pulse_pos, cmd_direction_pos} = 2'b00;
  // hold a level long enough to be captured
  task automatic hold();
    repeat (4) @(posedge clk);
    #5;
  endtask : hold
  // one command step in the chosen format
  task automatic step(input spio_fmt_t fmt, input logic up);
    if (fmt == SPIO_FMT_QUAD) begin
      {cmd_pulse_pos, cmd_direction_pos} = up ? {~cmd_direction_pos, cmd_pulse_pos} : {cmd_direction_pos, ~cmd_pulse_pos};
    end else begin
      if (fmt == SPIO_FMT_PULSE_SIGN) cmd_direction_pos = ~up; // sign settles before the pulse
      hold();
      if (up || fmt == SPIO_FMT_PULSE_SIGN) cmd_pulse_pos = 1'b1; else cmd_direction_pos = 1'b1;
      hold();
      cmd_pulse_pos = 1'b0;
      if (fmt != SPIO_FMT_PULSE_SIGN) cmd_direction_pos = 1'b0;
    end
    hold();
  endtask : step
endmodule : spio_host
`default_nettype wire

// ---- sim/spio_top_tb.sv ----
// Purpose: self-checking bench for pulse decode and status outputs
// Assumes: 20 MHz clock, inputs driven 5 ns after each rising edge
// Notes:   scaler guard cut to 20 cycles; 10 ms would dwarf the run
`timescale 1ns/1ps
`default_nettype none
module spio_top_tb;
  import spio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sc_sel = 1'b0;
  logic up;
  spio_fmt_t fmt = SPIO_FMT_CW_CCW;
  logic [15:0] num1 = 16'h0001;
  logic [15:0] num2 = 16'h0002;
  logic [15:0] thr = 16'h0000;
  logic [15:0] spd = 16'h0000;
  logic [2:0] sel = SPIO_SEL_RESET;
  spio_cond_t cond = '0;
  wire logic cmd_pulse_pos;
  wire logic cmd_direction_pos;
  wire logic signed [31:0] cnt;
  wire logic signed [48:0] pos;
  wire logic stp;
  wire spio_status_t st;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_step = 0;
  int exp_step = 0;
  longint exp_cnt = 0;
  spio_fmt_t order [4] = '{SPIO_FMT_CW_CCW, SPIO_FMT_PULSE_SIGN, SPIO_FMT_QUAD, spio_fmt_t'(2'h3)};
  spio_top DUT (.clk(clk), .rst_n(rst_n), .cmd_pulse_pos(cmd_pulse_pos), .cmd_direction_pos(cmd_direction_pos),
    .scaler_select_closed(sc_sel), .pulse_format_setting(fmt), .scaler_numerator_first(num1),
    .scaler_numerator_second(num2), .status_out_select(sel), .zero_speed_threshold(thr),
    .motor_speed_abs(spd), .drive_cond(cond), .pulse_count(cnt), .position_command(pos),
    .step_pulse(stp), .status_out(st));
  spio_host host (.clk(clk), .cmd_pulse_pos(cmd_pulse_pos), .cmd_direction_pos(cmd_direction_pos));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // status word as the host should see it
  function automatic logic [3:0] exp_st(input spio_cond_t c, input logic [2:0] s, input logic lo);
    logic [7:0] pick;
    pick = {2'b00, c.battery_warn | c.trip, c.overload_warn | c.trip, c.regen_warn | c.trip,
            c.regen_warn | c.overload_warn | c.battery_warn | c.trip, lo, c.torque_limiting};
    return {~c.trip, c.main_power_drive & c.main_power_motor & ~c.trip, c.brake_release_req, pick[s]};
  endfunction : exp_st
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    forever #25 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  // tally step pulses on the falling edge, where the registered pulse has settled
  always @(negedge clk) if (stp === 1'b1) n_step++;
  initial begin
    void'($urandom(75));
    repeat (12) @(posedge clk);
    #5 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #5;
    // every selector code with random conditions; small speeds hit the threshold boundary
    for (int i = 0; i < 48; i++) begin
      sel = 3'(i % 8);
      cond = spio_cond_t'(8'($urandom));
      spd = 16'($urandom_range(0, 3));
      thr = 16'($urandom_range(0, 3));
      @(posedge clk);
      #5;
      check(64'(st), 64'(exp_st(cond, sel, spd < thr)));
    end
    // each format in turn, then the unused code, alternating the scaler switch
    foreach (order[k]) begin
      fmt = order[k];
      sc_sel = k[0];
      num1 = 16'($urandom);
      num2 = 16'($urandom);
      repeat (20) @(posedge clk); // quiet time around the scaler switch
      #5;
      for (int j = 0; j < 6; j++) begin
        up = (j == 0) ? 1'b0 : 1'($urandom);
        host.step(fmt, up);
        exp_cnt += (k == 3) ? 0 : (up ? 1 : -1);
        exp_step += (k == 3) ? 0 : 1;
      end
      repeat (6) @(posedge clk);
      #5;
      check(64'(cnt), 64'(exp_cnt));
      check(64'(pos), 64'(exp_cnt * (sc_sel ? num2 : num1)));
    end
    check(64'(n_step), 64'(exp_step));
    wrap_up();
  end
endmodule : spio_top_tb
`default_nettype wire
